// ==== core/tws_pkg.sv ====
// Constants and types of the two-wire register access slave
package tws_pkg;

   // =========================================================
   // Widths
   localparam int TWS_ADDR_W = 16;
   localparam int TWS_DATA_W = 8;
   localparam int TWS_SYNC_N = 3;

   // =========================================================
   // Device address, bits [7:1] of the address byte
   localparam logic [6:0] TWS_DEV_ADDR_DEF = 7'h36;
   localparam logic [6:0] TWS_DEV_ADDR_ALT = 7'h37;

   // =========================================================
   // Bit counter positions within one byte plus acknowledge
   localparam logic [3:0] TWS_FIRST_BIT = 4'h1;
   localparam logic [3:0] TWS_LAST_BIT = 4'h7;
   localparam logic [3:0] TWS_ACK_SLOT = 4'h8;

   // =========================================================
   // Reset values and pointer step
   localparam logic [15:0] TWS_PTR_RESET = 16'h0000;
   localparam logic [7:0] TWS_DATA_RESET = 8'h00;
   localparam logic [15:0] TWS_PTR_STEP = 16'h0001;

   // =========================================================
   // Link sequencer states
   typedef enum logic [2:0] {
      TWS_ST_IDLE,
      TWS_ST_DEV,
      TWS_ST_REG_HI,
      TWS_ST_REG_LO,
      TWS_ST_WDATA,
      TWS_ST_READ,
      TWS_ST_IGNORE
   } tws_state_e;

endpackage

// ==== core/tws_xfer_if.sv ====
// Carrier between the link-side engine and the register-side bridge
`timescale 1ns/100ps
interface tws_xfer_if;
   import tws_pkg::*;

   logic req_tgl;
   logic req_wr;
   logic [TWS_ADDR_W-1:0] req_addr;
   logic [TWS_DATA_W-1:0] req_data;
   logic start_tgl;
   logic stop_tgl;
   logic [TWS_DATA_W-1:0] rd_data;

   modport link (
      output req_tgl,
      output req_wr,
      output req_addr,
      output req_data,
      output start_tgl,
      output stop_tgl,
      input rd_data
   );

   modport core (
      input req_tgl,
      input req_wr,
      input req_addr,
      input req_data,
      input start_tgl,
      input stop_tgl,
      output rd_data
   );

endinterface

// ==== core/tws_reg_bridge.sv ====
// Register-side bridge: turns link requests into register strobes
`timescale 1ns/100ps
module tws_reg_bridge (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Link side
   tws_xfer_if.core xfer,
   // Register port
   output logic [tws_pkg::TWS_ADDR_W-1:0] reg_addr,
   output logic [tws_pkg::TWS_DATA_W-1:0] reg_wdata,
   output logic reg_we,
   output logic reg_re,
   input wire logic [tws_pkg::TWS_DATA_W-1:0] reg_rdata,
   output logic link_busy
);
   import tws_pkg::*;

   logic [TWS_SYNC_N-1:0] tgl_raw;
   logic [TWS_SYNC_N-1:0] tgl_s1_q;
   logic [TWS_SYNC_N-1:0] tgl_s2_q;
   logic [TWS_SYNC_N-1:0] tgl_seen_q;
   logic [TWS_SYNC_N-1:0] tgl_evt;
   logic [TWS_DATA_W-1:0] rd_data_q;

   assign tgl_raw = {xfer.stop_tgl, xfer.start_tgl, xfer.req_tgl};

   // =========================================================
   // Toggle synchronisers, one per link event
   genvar gi;
   generate
      for (gi = 0; gi < TWS_SYNC_N; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               tgl_s1_q[gi] <= 1'b0;
               tgl_s2_q[gi] <= 1'b0;
               tgl_seen_q[gi] <= 1'b0;
            end else begin
               tgl_s1_q[gi] <= tgl_raw[gi];
               tgl_s2_q[gi] <= tgl_s1_q[gi];
               tgl_seen_q[gi] <= tgl_s2_q[gi];
            end
         end
         assign tgl_evt[gi] = tgl_s2_q[gi] ^ tgl_seen_q[gi];
      end
   endgenerate

   // =========================================================
   // Register strobes; payload is held stable by the link
   // until its next request, so it is sampled after the sync
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_we <= 1'b0;
         reg_re <= 1'b0;
         reg_addr <= TWS_PTR_RESET;
         reg_wdata <= TWS_DATA_RESET;
      end else begin
         reg_we <= tgl_evt[0] & xfer.req_wr;
         reg_re <= tgl_evt[0] & ~xfer.req_wr;
         if (tgl_evt[0]) begin
            reg_addr <= xfer.req_addr;
            reg_wdata <= xfer.req_data;
         end
      end
   end

   // =========================================================
   // Read data captured in the strobe cycle, held for the link
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q <= TWS_DATA_RESET;
      end else if (reg_re) begin
         rd_data_q <= reg_rdata;
      end
   end

   assign xfer.rd_data = rd_data_q;

   // =========================================================
   // Bus busy between start and stop
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         link_busy <= 1'b0;
      end else if (tgl_evt[1]) begin
         link_busy <= 1'b1;
      end else if (tgl_evt[2]) begin
         link_busy <= 1'b0;
      end
   end

endmodule // tws_reg_bridge

// ==== core/tws_slave_top.sv ====
// Two-wire register access slave: serial engine and top level
`timescale 1ns/100ps
module tws_slave_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Serial link, clock from the master
   input wire logic serial_clock,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe,
   // Address selection pins
   input wire logic alternate_address_select,
   input wire logic alt_addr_enable,
   // Register port
   output logic [tws_pkg::TWS_ADDR_W-1:0] reg_addr,
   output logic [tws_pkg::TWS_DATA_W-1:0] reg_wdata,
   output logic reg_we,
   output logic reg_re,
   input wire logic [tws_pkg::TWS_DATA_W-1:0] reg_rdata,
   // Status
   output logic link_busy
);
   import tws_pkg::*;

   tws_xfer_if xfer ();

   tws_state_e state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic ack_q;
   logic oe_q;
   logic [15:0] ptr_q;
   logic start_tgl_q;
   logic stop_tgl_q;
   logic start_seen_q;
   logic req_tgl_q;
   logic req_wr_q;
   logic [15:0] req_addr_q;
   logic [7:0] req_data_q;
   logic alt_s1_q;
   logic alt_s2_q;
   logic fresh_start;
   logic active;
   logic byte_done;
   logic in_ack;
   logic [7:0] rx_byte;
   logic [6:0] own_addr;
   logic addr_match;
   logic [15:0] ptr_next;

   // =========================================================
   // Start and stop detection: the data line acts as clock
   // because both conditions happen while the serial clock
   // is high and gives no edge of its own
   always_ff @(negedge serial_data_line_i or negedge rst_b) begin
      if (!rst_b) begin
         start_tgl_q <= 1'b0;
      end else if (serial_clock) begin
         start_tgl_q <= ~start_tgl_q;
      end
   end

   always_ff @(posedge serial_data_line_i or negedge rst_b) begin
      if (!rst_b) begin
         stop_tgl_q <= 1'b0;
      end else if (serial_clock) begin
         stop_tgl_q <= ~stop_tgl_q;
      end
   end

   // =========================================================
   // Alternate address pins, synchronised to the link clock
   always_ff @(posedge serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         alt_s1_q <= 1'b0;
         alt_s2_q <= 1'b0;
      end else begin
         alt_s1_q <= alternate_address_select & alt_addr_enable;
         alt_s2_q <= alt_s1_q;
      end
   end

   // =========================================================
   // Decode of the current bit slot
   assign fresh_start = start_tgl_q ^ start_seen_q;
   assign active = (state_q != TWS_ST_IDLE) &&
                   (state_q != TWS_ST_IGNORE);
   assign byte_done = !fresh_start && active &&
                      (bit_cnt_q == TWS_LAST_BIT);
   assign in_ack = !fresh_start && active &&
                   (bit_cnt_q == TWS_ACK_SLOT);
   assign rx_byte = {shift_q[6:0], serial_data_line_i};
   assign own_addr = alt_s2_q ? TWS_DEV_ADDR_ALT
                              : TWS_DEV_ADDR_DEF;
   assign addr_match = (rx_byte[7:1] == own_addr);
   assign ptr_next = ptr_q + TWS_PTR_STEP;

   // =========================================================
   // Start bookkeeping
   always_ff @(posedge serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         start_seen_q <= 1'b0;
      end else begin
         start_seen_q <= start_tgl_q;
      end
   end

   // =========================================================
   // Bit counter and receive shifter, sampled on rising clock
   always_ff @(posedge serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_q <= 4'h0;
         shift_q <= TWS_DATA_RESET;
      end else if (fresh_start) begin
         bit_cnt_q <= TWS_FIRST_BIT;
         shift_q <= {7'h00, serial_data_line_i};
      end else if (active) begin
         if (bit_cnt_q == TWS_ACK_SLOT) begin
            bit_cnt_q <= 4'h0;
         end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         shift_q <= rx_byte;
      end
   end

   // =========================================================
   // Sequencer; a start mid-byte drops the byte unwritten
   always_ff @(posedge serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= TWS_ST_IDLE;
      end else if (fresh_start) begin
         state_q <= TWS_ST_DEV;
      end else if (byte_done) begin
         case (state_q)
            TWS_ST_DEV: begin
               if (!addr_match) begin
                  state_q <= TWS_ST_IGNORE;
               end else if (rx_byte[0]) begin
                  state_q <= TWS_ST_READ;
               end else begin
                  state_q <= TWS_ST_REG_HI;
               end
            end
            TWS_ST_REG_HI: begin
               state_q <= TWS_ST_REG_LO;
            end
            TWS_ST_REG_LO: begin
               state_q <= TWS_ST_WDATA;
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end else if (in_ack && state_q == TWS_ST_READ &&
                   serial_data_line_i) begin
         state_q <= TWS_ST_IGNORE;
      end
   end

   // =========================================================
   // Acknowledge decision, taken when a byte completes
   always_ff @(posedge serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
      end else if (byte_done) begin
         if (state_q == TWS_ST_DEV) begin
            ack_q <= addr_match;
         end else begin
            ack_q <= (state_q != TWS_ST_READ);
         end
      end
   end

   // =========================================================
   // Register address pointer
   always_ff @(posedge serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         ptr_q <= TWS_PTR_RESET;
      end else if (byte_done) begin
         case (state_q)
            TWS_ST_REG_HI: begin
               ptr_q[15:8] <= rx_byte;
            end
            TWS_ST_REG_LO: begin
               ptr_q[7:0] <= rx_byte;
            end
            TWS_ST_WDATA, TWS_ST_READ: begin
               ptr_q <= ptr_next;
            end
            default: begin
               ptr_q <= ptr_q;
            end
         endcase
      end
   end

   // =========================================================
   // Requests toward the register side. Reads are fetched one
   // byte ahead so data is ready at the falling edge after the ack slot; the
   // cost is one extra read at the end of every read frame.
   always_ff @(posedge serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         req_tgl_q <= 1'b0;
         req_wr_q <= 1'b0;
         req_addr_q <= TWS_PTR_RESET;
         req_data_q <= TWS_DATA_RESET;
      end else if (byte_done) begin
         if (state_q == TWS_ST_DEV && addr_match && rx_byte[0]) begin
            req_tgl_q <= ~req_tgl_q;
            req_wr_q <= 1'b0;
            req_addr_q <= ptr_q;
         end else if (state_q == TWS_ST_WDATA) begin
            req_tgl_q <= ~req_tgl_q;
            req_wr_q <= 1'b1;
            req_addr_q <= ptr_q;
            req_data_q <= rx_byte;
         end else if (state_q == TWS_ST_READ) begin
            req_tgl_q <= ~req_tgl_q;
            req_wr_q <= 1'b0;
            req_addr_q <= ptr_next;
         end
      end
   end

   // =========================================================
   // Data line drive, changed only on the falling clock
   always_ff @(negedge serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         oe_q <= 1'b0;
         tx_q <= TWS_DATA_RESET;
      end else if (active && bit_cnt_q == TWS_ACK_SLOT) begin
         oe_q <= ack_q;
      end else if (state_q == TWS_ST_READ) begin
         if (bit_cnt_q == 4'h0) begin
            tx_q <= xfer.rd_data;
            oe_q <= ~xfer.rd_data[7];
         end else begin
            oe_q <= ~tx_q[3'(TWS_LAST_BIT - bit_cnt_q)];
         end
      end else begin
         oe_q <= 1'b0;
      end
   end

   // Open drain: only ever pulls low; clock is never driven
   assign serial_data_line_o = 1'b0;
   assign serial_data_line_oe = oe_q;

   // =========================================================
   // Link signals onto the carrier
   assign xfer.req_tgl = req_tgl_q;
   assign xfer.req_wr = req_wr_q;
   assign xfer.req_addr = req_addr_q;
   assign xfer.req_data = req_data_q;
   assign xfer.start_tgl = start_tgl_q;
   assign xfer.stop_tgl = stop_tgl_q;

   tws_reg_bridge u_bridge (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .xfer(xfer.core),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_we(reg_we),
      .reg_re(reg_re),
      .reg_rdata(reg_rdata),
      .link_busy(link_busy)
   );

endmodule // tws_slave_top

// ==== verification/tws_slave_monitor.sv ====
// Port checker of the two-wire register access slave
`timescale 1ns/100ps
module tws_slave_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Serial link
   input wire logic serial_clock,
   input wire logic serial_data_line_i,
   input wire logic serial_data_line_o,
   input wire logic serial_data_line_oe,
   // Register port and status
   input wire logic [tws_pkg::TWS_ADDR_W-1:0] reg_addr,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic link_busy
);
   import tws_pkg::*;
   // ==========================================================
   // Properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence s_start; serial_clock && $fell(serial_data_line_i); endsequence
   sequence s_stop; serial_clock && $rose(serial_data_line_i); endsequence
   property p_start_busy; s_start |-> ##[1:6] link_busy; endproperty
   property p_stop_idle; s_stop |-> ##[1:6] !link_busy; endproperty
   property p_od_low; serial_data_line_o == 1'b0; endproperty
   // Drive may only move while the master holds the clock low
   property p_oe_edge; $changed(serial_data_line_oe) |-> !serial_clock;
   endproperty
   property p_idle_quiet;
      !link_busy |-> !(reg_we || reg_re || serial_data_line_oe);
   endproperty
   property p_pulse; (reg_we || reg_re) |=> !(reg_we || reg_re); endproperty
   property p_one_req; !(reg_we && reg_re); endproperty
   property p_addr_req; $changed(reg_addr) |-> (reg_we || reg_re); endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("busy not raised after start");
   a_stop_idle: assert property (p_stop_idle)
      else $error("busy not dropped after stop");
   a_od_low: assert property (p_od_low)
      else $error("data output not low");
   a_oe_edge: assert property (p_oe_edge)
      else $error("data drive changed while clock high");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("activity while link idle");
   a_pulse: assert property (p_pulse)
      else $error("strobe longer than one cycle");
   a_one_req: assert property (p_one_req)
      else $error("read and write strobe together");
   a_addr_req: assert property (p_addr_req)
      else $error("address moved without strobe");
endmodule // tws_slave_monitor

bind tws_slave_top tws_slave_monitor i_mon (
   .ref_clk(ref_clk), .rst_b(rst_b), .serial_clock(serial_clock),
   .serial_data_line_i(serial_data_line_i),
   .serial_data_line_o(serial_data_line_o),
   .serial_data_line_oe(serial_data_line_oe),
   .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re),
   .link_busy(link_busy)
);

// ==== verification/tws_master_model.sv ====
// Behavioural two-wire bus master driving the slave's link
`timescale 1ns/100ps
module tws_master_model #(
   // Ten ticks of 48 ns; a read fetch takes up to 200 ns and must fit in three halves
   parameter int HALF_NS = 480
) (
   // Link outputs
   output logic serial_clock,
   output logic pull_low,
   // Resolved data wire
   input wire logic line_level
);
   // ==========================================================
   // Bus elements; clock stands high between frames
   initial begin
      serial_clock = 1'b1;
      pull_low = 1'b0;
   end
   task automatic start_cond();
      #(HALF_NS/2) pull_low = 1'b0;
      #(HALF_NS/2) serial_clock = 1'b1;
      #(HALF_NS) pull_low = 1'b1;
      #(HALF_NS) serial_clock = 1'b0;
   endtask
   task automatic stop_cond();
      #(HALF_NS/2) pull_low = 1'b1;
      #(HALF_NS/2) serial_clock = 1'b1;
      #(HALF_NS) pull_low = 1'b0;
      #(HALF_NS);
   endtask
   task automatic bit_cycle(input logic b, output logic seen);
      #(HALF_NS/2) pull_low = !b;
      #(HALF_NS/2) serial_clock = 1'b1;
      #(HALF_NS/2) seen = line_level;
      #(HALF_NS/2) serial_clock = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic nack);
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], nack);
      end
      bit_cycle(1'b1, nack);
   endtask
   task automatic recv_byte(input logic give_ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, d[i]);
      end
      bit_cycle(!give_ack, s);
   endtask
endmodule // tws_master_model

// ==== verification/tb.sv ====
// Self-checking bench of the two-wire register access slave
`timescale 1ns/100ps
module tb;
   import tws_pkg::*;
   // ==========================================================
   // Signals and model state
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic serial_clock;
   logic pull_low;
   logic sda_o;
   logic sda_oe;
   logic alt_sel = 1'b0;
   logic alt_en = 1'b0;
   logic [TWS_ADDR_W-1:0] reg_addr;
   logic [TWS_DATA_W-1:0] reg_wdata;
   logic reg_we;
   logic reg_re;
   logic [TWS_DATA_W-1:0] reg_rdata;
   logic link_busy;
   wire logic sda_level;
   logic [7:0] rf [logic [15:0]];
   logic [23:0] wq [$];
   logic [23:0] eq [$];
   logic [15:0] ptr = 16'h0000;
   logic [15:0] a;
   logic s;
   logic [31:0] lfsr_q = 32'h9119338e;
   int err_total = 0;
   int check_count = 0;
   // Register reads seen on the port and expected from the link
   int rd_seen = 0;
   int rd_exp = 0;
   // Pull-up: the wire is low only while someone pulls it
   assign sda_level = !(pull_low || (sda_oe && !sda_o));
   tws_slave_top i_dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .serial_clock(serial_clock),
      .serial_data_line_i(sda_level), .serial_data_line_o(sda_o),
      .serial_data_line_oe(sda_oe), .alternate_address_select(alt_sel),
      .alt_addr_enable(alt_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .link_busy(link_busy)
   );
   tws_master_model i_mst (
      .serial_clock(serial_clock), .pull_low(pull_low),
      .line_level(sda_level)
   );
   initial begin
      forever #25 ref_clk = !ref_clk;
   end
   // ==========================================================
   // Register file behind the port
   function automatic logic [7:0] peek(input logic [15:0] x);
      return rf.exists(x) ? rf[x] : x[7:0] ^ 8'h5a;
   endfunction
   always @(reg_addr or reg_we) reg_rdata = peek(reg_addr);
   always @(posedge ref_clk) begin
      if (reg_we === 1'b1) begin
         rf[reg_addr] = reg_wdata;
         wq.push_back({reg_addr, reg_wdata});
      end
      if (reg_re === 1'b1) begin
         rd_seen++;
      end
   end
   // ==========================================================
   // Helpers
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
      return lfsr_q[7:0];
   endfunction
   task automatic chk_ack(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_val(input string what, input logic [23:0] exp,
      input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic note(input string t);
      $display("test %s finished", t);
   endtask
   task automatic send(input logic [7:0] d, input logic exp_nack);
      logic nk;
      i_mst.send_byte(d, nk);
      chk_ack("ack", exp_nack, nk);
   endtask
   task automatic end_frame();
      i_mst.stop_cond();
      repeat (8) @(posedge ref_clk);
      chk_val("writes", 24'(eq.size()), 24'(wq.size()));
      chk_val("reads", 24'(rd_exp), 24'(rd_seen));
      while (eq.size() > 0 && wq.size() > 0) begin
         chk_val("write", eq.pop_front(), wq.pop_front());
      end
      eq.delete();
      wq.delete();
   endtask
   task automatic set_addr(input logic [15:0] x);
      i_mst.start_cond();
      send(8'h6c, 1'b0);
      send(x[15:8], 1'b0);
      send(x[7:0], 1'b0);
      ptr = x;
   endtask
   task automatic write_seq(input logic [15:0] x, input int n);
      logic [7:0] d;
      set_addr(x);
      repeat (n) begin
         d = rnd();
         send(d, 1'b0);
         eq.push_back({ptr, d});
         ptr++;
      end
      end_frame();
   endtask
   task automatic read_seq(input int n);
      logic [7:0] d;
      i_mst.start_cond();
      send(8'h6d, 1'b0);
      for (int i = 1; i <= n; i++) begin
         i_mst.recv_byte(i < n, d);
         chk_val("read", {ptr, peek(ptr)}, {ptr, d});
         ptr++;
      end
      #100;
      chk_ack("release", 1'b1, sda_level);
      // One byte is fetched ahead, so the port sees one read extra
      rd_exp += n + 1;
      end_frame();
   endtask
   // ==========================================================
   // Main sequence and watchdog
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk_ack("busy", 1'b0, link_busy);
      chk_ack("drive", 1'b0, sda_oe);
      note("reset");
      for (int k = 3; k >= 0; k--) begin
         @(posedge ref_clk);
         alt_sel <= k[0];
         alt_en <= k[1];
         repeat (4) @(posedge ref_clk);
         for (int b = 0; b < 2; b++) begin
            i_mst.start_cond();
            send(b == 1 ? 8'h6e : 8'h6c, (k == 3) != (b == 1));
            end_frame();
         end
      end
      note("address select");
      i_mst.start_cond();
      send(8'h50, 1'b1);
      send(rnd(), 1'b1);
      end_frame();
      note("mismatch");
      a = {rnd(), rnd()};
      write_seq(a, 3);
      note("write");
      set_addr(a);
      read_seq(3);
      read_seq(1);
      note("read");
      a = {rnd(), rnd()};
      set_addr(a);
      for (int i = 0; i < 4; i++) begin
         i_mst.bit_cycle(1'b1, s);
      end
      end_frame();
      read_seq(1);
      note("abort");
      results();
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      err_total++;
      results();
   end
endmodule // tb
